// [inc/gdpsr_defines.svh]
// Purpose: offsets, field positions, reset values for the primary status words
// Assumes: registers addressed wordwise
// Notes: definitions only
`ifndef GDPSR_DEFINES_SVH
`define GDPSR_DEFINES_SVH
`define GDPSR_OFS_STATUS 5'h01
`define GDPSR_OFS_STATUS2 5'h02
`define GDPSR_RST_STATUS 16'h087D
`define GDPSR_RST_STATUS2 16'h0010
`define GDPSR_BIT_PARITY 0
`define GDPSR_BIT_MSG_BAD 1
`define GDPSR_BIT_ERR 11
`define GDPSR_ONP_HI 9
`define GDPSR_ONP_LO 8
`define GDPSR_BIT_RUN 7
`define GDPSR_BIT_SEC_RDY 6
`define GDPSR_OFP_HI 5
`define GDPSR_OFP_LO 2
`define GDPSR_BIT_FLOAT_CTL 11
`define GDPSR_BIT_XCOND 10
`define GDPSR_BIT_HOT 9
`define GDPSR_BIT_FLOATED 8
`define GDPSR_MODE_HI 7
`define GDPSR_MODE_LO 5
`define GDPSR_BIT_FAULT_B 4
`define GDPSR_BIT_FAULT_A 3
`define GDPSR_BIT_EN_OK 2
`define GDPSR_MODE_ACTIVE 3'h4
`define GDPSR_MODE_RESVD 3'h7
`define GDPSR_READ_ZERO 16'h0000
`endif

// [inc/gdpsr_pkg.sv]
// Purpose: shared types for the primary status words
// Assumes: nothing
// Notes: register select enumerated
package gdpsr_pkg;
  typedef logic [15:0] gdpsr_word_t;
  typedef enum logic [1:0] {GDPSR_SEL_NONE, GDPSR_SEL_ONE, GDPSR_SEL_TWO} gdpsr_sel_t;
endpackage

// [rtl/gdpsr_parity.sv]
// Purpose: fill bit 0 so the word has odd weight
// Assumes: bit 0 of the input is don't care
// Notes: combinational
`timescale 1ns/1ps
module gdpsr_parity (
  input wire logic [15:0] rawWord,
  output logic [15:0] oddWord
);
  wire upperOnes = ^rawWord[15:1];
  assign oddWord = {rawWord[15:1], ~upperOnes};
endmodule // gdpsr_parity

// [rtl/gdpsr_sticky.sv]
// Purpose: one sticky flag that leaves its reset value only once
// Assumes: synchronous active high reset
// Notes: only reset returns it
`timescale 1ns/1ps
module gdpsr_sticky #(
  parameter logic resetValue = 1'b0
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic setEvent,
  output logic flag
);
  always_ff @(posedge clk) begin
    if (reset) begin
      flag <= resetValue;
    end else if (setEvent) begin
      flag <= 1'b1;
    end
  end
endmodule // gdpsr_sticky

// [rtl/gate_driver_primary_status_regs.sv]
// Purpose: read-only primary status words of an isolated gate driver
// Assumes: read select comes from the serial frame decoder, one clock
// Notes: mirrored inputs are already synchronous to clk
// What this block does
// - error bit is OR of error register
// - turn-on plateau field holds latest request
// - running flag high only in mode four
// - secondary ready bit follows secondary readiness
// - turn-off plateau field holds latest request
// - last message invalid in both words
// - bit 0 is odd parity, both words
// - float control bit mirrors secondary control
// - cross conduction bit while inhibition runs
// - over temperature bit mirrors secondary status
// - output floated bit mirrors secondary status
// - operating state field mirrors secondary mode, reserved code ignored
// - fault b request sticky when pin driven
// - fault a request sticky when pin driven
// - enable valid bit follows enable judgement
// - fault a sticky bit clears only by reset; fault b resets set and never clears
`timescale 1ns/1ps
`include "gdpsr_defines.svh"
module gate_driver_primary_status_regs (
  input wire logic clk,
  input wire logic reset,
  input wire logic [4:0] regAddr,
  input wire logic readStrobe,
  input wire logic writeStrobe,
  input wire logic [15:0] writeData,
  input wire logic [15:0] errorRegister,
  input wire logic onPlateauReq,
  input wire logic [1:0] onPlateauCode,
  input wire logic offPlateauReq,
  input wire logic [3:0] offPlateauCode,
  input wire logic messageDone,
  input wire logic messageDiscarded,
  input wire logic secReady,
  input wire logic secFloatControl,
  input wire logic inhibitRunning,
  input wire logic secOverTemp,
  input wire logic secFloated,
  input wire logic [2:0] secMode,
  input wire logic faultPinBDriveLow,
  input wire logic faultPinADriveLow,
  input wire logic enableValid,
  output logic [15:0] readData,
  output logic readValid,
  output logic [15:0] primary_status_word,
  output logic [15:0] primary_status_word_two
);
  logic faultSummary;
  logic [1:0] onPlateau;
  logic [3:0] offPlateau;
  logic lastInvalid;
  logic runFlag;
  logic secRdy;
  logic floatCtl;
  logic xcondBlock;
  logic hotFlag;
  logic floatedFlag;
  logic [2:0] opMode;
  logic enableOk;
  logic fault_out_b_request;
  logic fault_out_a_request;
  logic [15:0] raw1;
  logic [15:0] raw2;
  logic [15:0] word1;
  logic [15:0] word2;
  gdpsr_pkg::gdpsr_sel_t sel;
  localparam gdpsr_pkg::gdpsr_word_t resetOne = `GDPSR_RST_STATUS;
  localparam gdpsr_pkg::gdpsr_word_t resetTwo = `GDPSR_RST_STATUS2;

  // writes are accepted by the frame decoder and dropped here
  wire writeIgnored = writeStrobe & (|writeData);
  wire hitOne = regAddr == `GDPSR_OFS_STATUS;
  wire hitTwo = regAddr == `GDPSR_OFS_STATUS2;
  wire modeLegal = secMode != `GDPSR_MODE_RESVD;
  wire [2:0] next_opMode = modeLegal ? secMode : opMode;
  wire next_runFlag = next_opMode == `GDPSR_MODE_ACTIVE;
  wire next_lastInvalid = messageDiscarded ? 1'b1 : (messageDone ? 1'b0 : lastInvalid);

  assign sel = !readStrobe ? gdpsr_pkg::GDPSR_SEL_NONE :
               hitOne ? gdpsr_pkg::GDPSR_SEL_ONE :
               hitTwo ? gdpsr_pkg::GDPSR_SEL_TWO : gdpsr_pkg::GDPSR_SEL_NONE;
  wire readMapped = sel != gdpsr_pkg::GDPSR_SEL_NONE;

  always_comb begin
    raw1 = `GDPSR_READ_ZERO;
    raw1[`GDPSR_BIT_ERR] = faultSummary;
    raw1[`GDPSR_ONP_HI:`GDPSR_ONP_LO] = onPlateau;
    raw1[`GDPSR_BIT_RUN] = runFlag;
    raw1[`GDPSR_BIT_SEC_RDY] = secRdy;
    raw1[`GDPSR_OFP_HI:`GDPSR_OFP_LO] = offPlateau;
    raw1[`GDPSR_BIT_MSG_BAD] = lastInvalid;
  end

  always_comb begin
    raw2 = `GDPSR_READ_ZERO;
    raw2[`GDPSR_BIT_FLOAT_CTL] = floatCtl;
    raw2[`GDPSR_BIT_XCOND] = xcondBlock;
    raw2[`GDPSR_BIT_HOT] = hotFlag;
    raw2[`GDPSR_BIT_FLOATED] = floatedFlag;
    raw2[`GDPSR_MODE_HI:`GDPSR_MODE_LO] = opMode;
    raw2[`GDPSR_BIT_FAULT_B] = fault_out_b_request;
    raw2[`GDPSR_BIT_FAULT_A] = fault_out_a_request;
    raw2[`GDPSR_BIT_EN_OK] = enableOk;
    raw2[`GDPSR_BIT_MSG_BAD] = lastInvalid;
  end

  gdpsr_parity parityOne (
    .rawWord(raw1),
    .oddWord(word1)
  );
  gdpsr_parity parityTwo (
    .rawWord(raw2),
    .oddWord(word2)
  );

  // fault b leaves reset already requesting, so its flag starts set
  gdpsr_sticky #(.resetValue(resetTwo[`GDPSR_BIT_FAULT_B])) stickyB (
    .clk(clk),
    .reset(reset),
    .setEvent(faultPinBDriveLow),
    .flag(fault_out_b_request)
  );
  gdpsr_sticky #(.resetValue(resetTwo[`GDPSR_BIT_FAULT_A])) stickyA (
    .clk(clk),
    .reset(reset),
    .setEvent(faultPinADriveLow),
    .flag(fault_out_a_request)
  );

  always_ff @(posedge clk) begin
    if (reset) begin
      faultSummary <= resetOne[`GDPSR_BIT_ERR];
      onPlateau <= resetOne[`GDPSR_ONP_HI:`GDPSR_ONP_LO];
      offPlateau <= resetOne[`GDPSR_OFP_HI:`GDPSR_OFP_LO];
      runFlag <= resetOne[`GDPSR_BIT_RUN];
      secRdy <= resetOne[`GDPSR_BIT_SEC_RDY];
      lastInvalid <= resetOne[`GDPSR_BIT_MSG_BAD];
    end else begin
      faultSummary <= |errorRegister;
      if (onPlateauReq) begin
        onPlateau <= onPlateauCode;
      end
      if (offPlateauReq) begin
        offPlateau <= offPlateauCode;
      end
      runFlag <= next_runFlag;
      secRdy <= secReady;
      lastInvalid <= next_lastInvalid;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      floatCtl <= resetTwo[`GDPSR_BIT_FLOAT_CTL];
      xcondBlock <= resetTwo[`GDPSR_BIT_XCOND];
      hotFlag <= resetTwo[`GDPSR_BIT_HOT];
      floatedFlag <= resetTwo[`GDPSR_BIT_FLOATED];
      opMode <= resetTwo[`GDPSR_MODE_HI:`GDPSR_MODE_LO];
      enableOk <= resetTwo[`GDPSR_BIT_EN_OK];
    end else begin
      floatCtl <= secFloatControl;
      xcondBlock <= inhibitRunning;
      hotFlag <= secOverTemp;
      floatedFlag <= secFloated;
      opMode <= next_opMode;
      enableOk <= enableValid;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      readData <= `GDPSR_READ_ZERO;
      readValid <= 1'b0;
      primary_status_word <= `GDPSR_RST_STATUS;
      primary_status_word_two <= `GDPSR_RST_STATUS2;
    end else begin
      readValid <= readStrobe;
      unique case (sel)
        gdpsr_pkg::GDPSR_SEL_ONE: readData <= word1;
        gdpsr_pkg::GDPSR_SEL_TWO: readData <= word2;
        gdpsr_pkg::GDPSR_SEL_NONE: readData <= `GDPSR_READ_ZERO;
      endcase
      primary_status_word <= word1;
      primary_status_word_two <= word2;
    end
  end

  // the first edge after reset still shows reset values, so mirrors skip it
  a_error_summary: assert property (
    @(posedge clk) disable iff (reset)
    !$past(reset) |-> faultSummary == |$past(errorRegister)
  ) else $error("fault summary wrong");

  a_error_word: assert property (
    @(posedge clk) disable iff (reset)
    !$past(reset) |-> primary_status_word[`GDPSR_BIT_ERR] == $past(faultSummary)
  ) else $error("fault summary not in word one");

  a_on_plateau: assert property (
    @(posedge clk) disable iff (reset)
    onPlateauReq |=> onPlateau == $past(onPlateauCode)
  ) else $error("turn-on plateau not latched");

  a_on_plateau_hold: assert property (
    @(posedge clk) disable iff (reset)
    !onPlateauReq |=> $stable(onPlateau)
  ) else $error("turn-on plateau changed without request");

  a_run_flag_mode: assert property (
    @(posedge clk) disable iff (reset)
    runFlag == (opMode == `GDPSR_MODE_ACTIVE)
  ) else $error("run flag mismatch");

  a_sec_ready: assert property (
    @(posedge clk) disable iff (reset)
    !$past(reset) |-> secRdy == $past(secReady)
  ) else $error("secondary ready not mirrored");

  a_ready_word: assert property (
    @(posedge clk) disable iff (reset)
    !$past(reset) |-> primary_status_word[`GDPSR_BIT_SEC_RDY] == $past(secRdy)
  ) else $error("secondary ready not in word one");

  a_off_plateau: assert property (
    @(posedge clk) disable iff (reset)
    offPlateauReq |=> offPlateau == $past(offPlateauCode)
  ) else $error("turn-off plateau not latched");

  a_off_plateau_hold: assert property (
    @(posedge clk) disable iff (reset)
    !offPlateauReq |=> $stable(offPlateau)
  ) else $error("turn-off plateau changed without request");

  a_bad_msg_set: assert property (
    @(posedge clk) disable iff (reset)
    messageDiscarded |=> lastInvalid
  ) else $error("discard not flagged");

  a_bad_msg_clear: assert property (
    @(posedge clk) disable iff (reset)
    messageDone && !messageDiscarded |=> !lastInvalid
  ) else $error("invalid flag not cleared");

  a_bad_msg_both: assert property (
    @(posedge clk) disable iff (reset)
    primary_status_word[`GDPSR_BIT_MSG_BAD] == primary_status_word_two[`GDPSR_BIT_MSG_BAD]
  ) else $error("invalid flag differs between words");

  a_parity_odd: assert property (
    @(posedge clk) disable iff (reset)
    readValid && $past(readMapped) |-> ^readData
  ) else $error("read parity not odd");

  a_float_ctrl: assert property (
    @(posedge clk) disable iff (reset)
    !$past(reset) |-> floatCtl == $past(secFloatControl)
  ) else $error("float control not mirrored");

  a_xcond_mirror: assert property (
    @(posedge clk) disable iff (reset)
    inhibitRunning |=> ##1 primary_status_word_two[`GDPSR_BIT_XCOND]
  ) else $error("inhibit not shown");

  a_over_temp: assert property (
    @(posedge clk) disable iff (reset)
    !$past(reset) |-> hotFlag == $past(secOverTemp)
  ) else $error("over temperature not mirrored");

  a_output_float: assert property (
    @(posedge clk) disable iff (reset)
    !$past(reset) |-> floatedFlag == $past(secFloated)
  ) else $error("output float not mirrored");

  a_mode_mirror: assert property (
    @(posedge clk) disable iff (reset)
    !$past(reset) && $past(secMode) != `GDPSR_MODE_RESVD |-> opMode == $past(secMode)
  ) else $error("operating mode not mirrored");

  a_fault_b_set: assert property (
    @(posedge clk) disable iff (reset)
    faultPinBDriveLow |=> ##1 primary_status_word_two[`GDPSR_BIT_FAULT_B]
  ) else $error("fault b not reported");

  a_fault_a_set: assert property (
    @(posedge clk) disable iff (reset)
    faultPinADriveLow |=> ##1 primary_status_word_two[`GDPSR_BIT_FAULT_A]
  ) else $error("fault a not reported");

  a_enable_valid: assert property (
    @(posedge clk) disable iff (reset)
    !$past(reset) |-> enableOk == $past(enableValid)
  ) else $error("enable valid not mirrored");

  a_sticky_hold: assert property (
    @(posedge clk) disable iff (reset)
    primary_status_word_two[`GDPSR_BIT_FAULT_B] |=> primary_status_word_two[`GDPSR_BIT_FAULT_B]
  ) else $error("sticky fault b dropped");

  a_sticky_a_hold: assert property (
    @(posedge clk) disable iff (reset)
    fault_out_a_request |=> fault_out_a_request
  ) else $error("sticky fault a dropped");

  a_word_parity: assert property (
    @(posedge clk) disable iff (reset)
    ^primary_status_word && ^primary_status_word_two
  ) else $error("word parity even");

  a_mode_legal: assert property (
    @(posedge clk) disable iff (reset)
    opMode != `GDPSR_MODE_RESVD
  ) else $error("reserved mode reported");

  a_mode_hold: assert property (
    @(posedge clk) disable iff (reset)
    secMode == `GDPSR_MODE_RESVD |=> $stable(opMode)
  ) else $error("reserved mode not ignored");

  a_reserved_zero: assert property (
    @(posedge clk) disable iff (reset)
    primary_status_word[15:12] == 4'h0 && !primary_status_word[10]
    && primary_status_word_two[15:12] == 4'h0
  ) else $error("reserved bit set");

  a_unmapped_zero: assert property (
    @(posedge clk) disable iff (reset)
    readValid && !$past(readMapped) |-> readData == `GDPSR_READ_ZERO
  ) else $error("unmapped read not zero");

  c_read_one: cover property (
    @(posedge clk) readStrobe && hitOne
  );

  c_read_two: cover property (
    @(posedge clk) readStrobe && hitTwo
  );

  c_active_mode: cover property (
    @(posedge clk) runFlag
  );

  c_discard: cover property (
    @(posedge clk) messageDiscarded && writeIgnored
  );

  c_mode_reserved: cover property (
    @(posedge clk) secMode == `GDPSR_MODE_RESVD
  );
endmodule // gate_driver_primary_status_regs

// [bench/gdpsr_host.sv]
// Purpose: host model that reads the status words
// Assumes: one read in flight at a time
// Notes: drives on the falling edge
`timescale 1ns/1ps
module gdpsr_host (
  input wire logic clk,
  input wire logic [15:0] readData,
  input wire logic readValid,
  output logic readStrobe,
  output logic [4:0] regAddr
);
  initial begin
    readStrobe = 1'b0;
    regAddr = 5'h1F;
  end
  task automatic rd(input logic [4:0] a, output logic [15:0] d, output bit ok);
    ok = 1'b0;
    d = 16'h0000;
    @(negedge clk);
    regAddr = a;
    readStrobe = 1'b1;
    for (int i = 0; i < 3 && !ok; i++) begin
      @(negedge clk);
      readStrobe = 1'b0;
      // released address shows the inverse, not a stale value
      regAddr = ~a;
      if (readValid === 1'b1) begin
        d = readData;
        ok = 1'b1;
      end
    end
  endtask
endmodule // gdpsr_host

// [bench/testbench.sv]
// Purpose: random and corner tests of the primary status words
// Assumes: inputs change on the falling edge
// Notes: a model of the fields predicts every word
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("ERROR %s exp %h got %h", nm, e, g); end end
module testbench;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic readStrobe, readValid, writeStrobe, onPlateauReq, offPlateauReq, messageDone;
  logic messageDiscarded, secReady, secFloatControl, inhibitRunning, secOverTemp;
  logic secFloated, faultPinBDriveLow, faultPinADriveLow, enableValid;
  logic [1:0] onPlateauCode;
  logic [2:0] secMode;
  logic [3:0] offPlateauCode;
  logic [4:0] regAddr;
  logic [15:0] writeData, errorRegister, readData, primary_status_word, primary_status_word_two;
  logic [1:0] mOn;
  logic [3:0] mOff;
  logic [2:0] mMode;
  logic mBad, mFa;
  int seed = 32'h37F47C1F;
  int n_errors = 0;
  int num_checks = 0;
  always #2 clk = ~clk;
  gate_driver_primary_status_regs gate_driver_primary_status_regs_i (.clk, .reset, .regAddr,
    .readStrobe, .writeStrobe, .writeData, .errorRegister, .onPlateauReq, .onPlateauCode,
    .offPlateauReq, .offPlateauCode, .messageDone, .messageDiscarded, .secReady,
    .secFloatControl, .inhibitRunning, .secOverTemp, .secFloated, .secMode,
    .faultPinBDriveLow, .faultPinADriveLow, .enableValid, .readData, .readValid,
    .primary_status_word, .primary_status_word_two);
  gdpsr_host gdpsr_host_i (.clk, .readData, .readValid, .readStrobe, .regAddr);
  function automatic logic [15:0] par(input logic [15:0] w);
    return {w[15:1], ~^w[15:1]};
  endfunction
  function automatic logic [15:0] exp1();
    return par({4'h0, |errorRegister, 1'b0, mOn, mMode == 3'h4, secReady, mOff, mBad, 1'b0});
  endfunction
  function automatic logic [15:0] exp2();
    return par({4'h0, secFloatControl, inhibitRunning, secOverTemp, secFloated, mMode, 1'b1,
      mFa, enableValid, mBad, 1'b0});
  endfunction
  task wrap_up();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic rdChk(input logic [4:0] a, input logic [15:0] e);
    logic [15:0] d;
    bit ok;
    gdpsr_host_i.rd(a, d, ok);
    if (!ok) begin
      n_errors++;
      wrap_up();
    end else begin
      `CHK("readData", e, d)
    end
  endtask
  task automatic doReset(input int n);
    @(negedge clk);
    reset = 1'b1;
    secMode = 3'h0;
    faultPinADriveLow = 1'b0;
    repeat (n) @(negedge clk);
    `CHK("word one", 16'h087D, primary_status_word)
    `CHK("word two", 16'h0010, primary_status_word_two)
    `CHK("read idle", 17'h00000, {readValid, readData})
    reset = 1'b0;
    {mOn, mOff, mBad, mMode, mFa} = {2'h0, 4'hF, 1'b0, 3'h0, 1'b0};
    $display("test reset done");
  endtask
  task automatic stim(input int i);
    logic [31:0] r;
    r = $random(seed);
    @(negedge clk);
    {onPlateauReq, onPlateauCode, offPlateauReq, offPlateauCode} = r[7:0];
    {messageDone, messageDiscarded, secReady, secFloatControl} = r[11:8];
    {inhibitRunning, secOverTemp, secFloated, secMode, faultPinBDriveLow} = r[18:12];
    faultPinADriveLow = r[21:19] == 3'h0;
    {enableValid, writeStrobe} = r[23:22];
    writeData = r[31:16];
    errorRegister = r[24] ? 16'h0000 : 16'h0001 << r[28:25];
    // sweep all mode codes first, including the reserved one
    if (i < 8) secMode = i[2:0];
    if (i == 0) {messageDone, messageDiscarded} = 2'b11;
    if (onPlateauReq) mOn = onPlateauCode;
    if (offPlateauReq) mOff = offPlateauCode;
    if (messageDiscarded) mBad = 1'b1;
    else if (messageDone) mBad = 1'b0;
    if (secMode != 3'h7) mMode = secMode;
    if (faultPinADriveLow) mFa = 1'b1;
    @(negedge clk);
    {onPlateauReq, offPlateauReq, messageDone, messageDiscarded} = 4'h0;
    {writeStrobe, faultPinADriveLow} = 2'b00;
    @(negedge clk);
    `CHK("word one", exp1(), primary_status_word)
    `CHK("word two", exp2(), primary_status_word_two)
    rdChk(5'h01, exp1());
    rdChk(5'h02, exp2());
    rdChk(r[31] ? 5'h00 : {1'b1, r[3:0]}, 16'h0000);
  endtask
  initial begin
    {writeStrobe, writeData, errorRegister, onPlateauReq, onPlateauCode} = '0;
    {offPlateauReq, offPlateauCode, messageDone, messageDiscarded, secReady} = '0;
    {secFloatControl, inhibitRunning, secOverTemp, secFloated, secMode} = '0;
    {faultPinBDriveLow, faultPinADriveLow, enableValid} = '0;
    doReset(20);
    for (int i = 0; i < 60; i++) begin
      stim(i);
      if (i == 30) doReset(2);
    end
    $display("test random done");
    wrap_up();
  end
endmodule // testbench
